// >>> shared/ipirq_pkg.sv
package ipirq_pkg;
    // register indices (printed offsets not word aligned -> byte address is index * 4)
    localparam logic [15:0] IPIRQ_IDX_PRIORITY = 16'hFF20;
    localparam logic [15:0] IPIRQ_IDX_ENABLE = 16'hFF23;
    localparam logic [15:0] IPIRQ_IDX_FLAGS = 16'hFF27;
    localparam logic [15:0] IPIRQ_IDX_SELECT = 16'hFFC0;
    localparam logic [15:0] IPIRQ_IDX_BYTE_CMP = 16'hFFC1;
    localparam logic [15:0] IPIRQ_IDX_NIB_CMP = 16'hFFC2;
    localparam logic [15:0] IPIRQ_IDX_BYTE_DATA = 16'hFFC3;
    localparam logic [15:0] IPIRQ_IDX_NIB_DATA = 16'hFFC4;
    localparam logic [15:0] IPIRQ_IDX_IRQ_EN = 16'hFFD0;
    localparam logic [15:0] IPIRQ_IDX_IRQ_CLR = 16'hFFD1;
    // field positions
    localparam int IPIRQ_SYS_LSB = 3;
    localparam int IPIRQ_NIB_PRIO_LSB = 6;
    localparam int IPIRQ_BYTE_PRIO_LSB = 4;
    // reset values
    localparam logic [7:0] IPIRQ_RST_PRIORITY = 8'h00;
    localparam logic [4:0] IPIRQ_RST_ENABLE = 5'h00;
    localparam logic [4:0] IPIRQ_RST_FLAGS = 5'h00;
    localparam logic [7:0] IPIRQ_RST_SELECT = 8'h00;
    localparam logic [7:0] IPIRQ_RST_BYTE_CMP = 8'hFF;
    localparam logic [3:0] IPIRQ_RST_NIB_CMP = 4'hF;
    // exception vectors
    localparam logic [23:0] IPIRQ_VEC_NIB0 = 24'h000006;
    localparam logic [23:0] IPIRQ_VEC_STEP = 24'h000002;
    localparam logic [23:0] IPIRQ_VEC_BYTE = 24'h00000E;
endpackage

// >>> verif/ipirq_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ipirq_core_tb;
    import ipirq_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [17:0] adr = 18'h0;
    logic [31:0] dat = 32'h0, rdat, q;
    logic [3:0] sel = 4'h0, nset = 4'h0, npin, pn = 4'h0;
    logic [7:0] bset = 8'h00, bpin, pb = 8'h00, r;
    logic ack, err, irq, last_err;
    logic [4:0] req;
    logic [1:0] bpri, npri;
    logic [23:0] vb, v0, v1, v2, v3;
    logic [15:0] ridx [7] = '{IPIRQ_IDX_PRIORITY, IPIRQ_IDX_ENABLE, IPIRQ_IDX_FLAGS,
        IPIRQ_IDX_SELECT, IPIRQ_IDX_BYTE_CMP, IPIRQ_IDX_NIB_CMP, IPIRQ_IDX_IRQ_EN};
    logic [7:0] rval [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h0F, 8'h00};
    int bad_count = 0, checks = 0, cyc_n = 0;
    // model state: flags, enables, irq enables, select, compares
    int m_fl = 0, m_en = 0, m_ie = 0, m_sel = 0, m_bc = 255, m_nc = 15;
    ipirq_core DUT (
        .clk_i(clk_i), .rst_i(rst_i), .byte_input_group_i(bpin), .nibble_input_pin_i(npin),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .sys_req_o(req),
        .byte_group_priority_o(bpri), .nibble_group_priority_o(npri), .vec_byte_o(vb),
        .vec_nib0_o(v0), .vec_nib1_o(v1), .vec_nib2_o(v2), .vec_nib3_o(v3), .irq_o(irq)
    );
    ipirq_pin_model PINS (
        .clk_i(clk_i), .byte_set_i(bset), .nib_set_i(nset), .byte_o(bpin), .nib_o(npin)
    );
    always #2 clk_i = ~clk_i;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // classic single wishbone cycle, held until ack or err
    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        {cyc, stb, we, sel, adr, dat} <= {2'b11, w, 4'h1, idx, 2'b00, 24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
        q = rdat;
        last_err = err;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd(input string nm, input logic [15:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk(nm, {24'h0, e}, q);
    endtask
    // move the pins and predict the flags
    task automatic pins(input logic [7:0] b, input logic [3:0] n);
        if (((pb ^ m_bc) & m_sel) == 0 && ((b ^ m_bc) & m_sel) != 0) m_fl |= 1;
        for (int i = 0; i < 4; i++) if (pn[i] != n[i] && n[i] != m_nc[i]) m_fl |= 2 << i;
        pb = b;
        pn = n;
        @(posedge clk_i);
        {bset, nset} <= {b, n};
        repeat (6) @(posedge clk_i);
    endtask
    task automatic state();
        rd("flags", IPIRQ_IDX_FLAGS, 8'(m_fl << 3));
        chk("sys_req", 32'(m_fl & m_en), 32'(req));
        chk("irq", 32'(|(m_fl & m_ie)), 32'(irq));
    endtask
    initial begin
        void'($urandom(32'h4edf4168));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ridx[i]) rd("reset_value", ridx[i], rval[i]);
        chk("vec_byte", 32'hE, 32'(vb));
        chk("vec_nib0", 32'h6, 32'(v0));
        chk("vec_nib1", 32'h8, 32'(v1));
        chk("vec_nib2", 32'hA, 32'(v2));
        chk("vec_nib3", 32'hC, 32'(v3));
        r = 8'($urandom);
        bus(1'b1, IPIRQ_IDX_PRIORITY, r);
        rd("priority", IPIRQ_IDX_PRIORITY, r);
        chk("byte_prio", 32'(r[5:4]), 32'(bpri));
        chk("nib_prio", 32'(r[7:6]), 32'(npri));
        bus(1'b0, 16'h0001, 8'h00);
        chk("unmapped_err", 32'h1, 32'(last_err));
        $display("test registers done");
        // nibble edges, flag clearing, masking
        bus(1'b1, IPIRQ_IDX_ENABLE, 8'hF8);
        m_en = 31;
        bus(1'b1, IPIRQ_IDX_IRQ_EN, 8'hF8);
        m_ie = 31;
        bus(1'b1, IPIRQ_IDX_NIB_CMP, 8'h05);
        m_nc = 5;
        pins(8'h00, 4'hF);
        state();
        pins(8'h00, 4'h0);
        state();
        bus(1'b1, IPIRQ_IDX_FLAGS, 8'h10);
        m_fl &= ~2;
        state();
        bus(1'b1, IPIRQ_IDX_FLAGS, 8'h00);
        bus(1'b1, IPIRQ_IDX_ENABLE, 8'hA8);
        m_en = 21;
        bus(1'b1, IPIRQ_IDX_IRQ_EN, 8'h10);
        m_ie = 2;
        state();
        $display("test nibble done");
        // byte group match logic
        bus(1'b1, IPIRQ_IDX_SELECT, 8'hFE);
        m_sel = 254;
        bus(1'b1, IPIRQ_IDX_BYTE_CMP, 8'h00);
        m_bc = 0;
        pins(8'h00, 4'h0);
        bus(1'b1, IPIRQ_IDX_FLAGS, 8'hF8);
        bus(1'b1, IPIRQ_IDX_ENABLE, 8'hF8);
        bus(1'b1, IPIRQ_IDX_IRQ_EN, 8'h08);
        {m_fl, m_en, m_ie} = {32'd0, 32'd31, 32'd1};
        pins(8'h01, 4'h0);
        state();
        pins(8'h09, 4'h0);
        state();
        bus(1'b1, IPIRQ_IDX_FLAGS, 8'h08);
        m_fl = 0;
        pins(8'h19, 4'h0);
        state();
        pins(8'h01, 4'h0);
        pins(8'h21, 4'h0);
        state();
        bus(1'b1, IPIRQ_IDX_IRQ_CLR, 8'h08);
        m_fl &= ~1;
        state();
        repeat (8) begin
            pins(8'($urandom), 4'($urandom));
            state();
        end
        $display("test byte done");
        stop_test();
    end
endmodule
`default_nettype wire

// >>> verif/ipirq_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module ipirq_pin_model (
    input wire logic clk_i, // system clock
    input wire logic [7:0] byte_set_i, // wanted byte pin levels
    input wire logic [3:0] nib_set_i, // wanted nibble pin levels
    output logic [7:0] byte_o, // byte group pins
    output logic [3:0] nib_o // nibble pins
);
    // switches settle one edge after being moved, then hold their level
    always_ff @(posedge clk_i) begin
        byte_o <= byte_set_i;
        nib_o <= nib_set_i;
    end
endmodule
`default_nettype wire

// >>> verilog/ipirq_core.sv
`timescale 1ns/10ps
`default_nettype none
module ipirq_core
    import ipirq_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic rst_i, // sync reset, active high
    input wire logic [7:0] byte_input_group_i, // byte group pins
    input wire logic [3:0] nibble_input_pin_i, // nibble pins 3..0
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_we_i, // write enable
    input wire logic [17:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    output logic wb_err_o, // unmapped address
    output logic [4:0] sys_req_o, // per-system request, D7..D3 order
    output logic [1:0] byte_group_priority_o, // byte group level
    output logic [1:0] nibble_group_priority_o, // nibble group level
    output logic [23:0] vec_byte_o, // byte group vector
    output logic [23:0] vec_nib0_o, // nibble pin 0 vector
    output logic [23:0] vec_nib1_o, // nibble pin 1 vector
    output logic [23:0] vec_nib2_o, // nibble pin 2 vector
    output logic [23:0] vec_nib3_o, // nibble pin 3 vector
    output logic irq_o // summary interrupt
);
    logic [7:0] priority_reg;
    logic [4:0] enables; // [4:1] nibble 3..0, [0] byte group
    logic [4:0] flags;
    logic [7:0] byte_pin_select;
    logic [7:0] byte_pin_compare;
    logic [3:0] nibble_pin_compare;
    logic [4:0] irq_en;
    logic [7:0] byte_s1, byte_s2;
    logic [3:0] nib_s1, nib_s2, nib_prev;
    logic match_prev;
    logic match_now;
    logic [4:0] event_set;
    logic [4:0] clr_mask;
    logic [4:0] irq_clr;
    logic req_hit, wr_stb, mapped;
    logic [15:0] idx;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;

    // bus decode: register index is byte address / 4
    assign idx = wb_adr_i[17:2];
    assign req_hit = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wbyte = wb_dat_i[7:0];
    assign wr_stb = req_hit && mapped && wb_we_i && wb_sel_i[0] && (wb_adr_i[1:0] == 2'b00);
    always_comb begin
        mapped = 1'b1;
        rd_byte = 8'h00;
        unique case (idx)
            IPIRQ_IDX_PRIORITY: rd_byte = priority_reg;
            IPIRQ_IDX_ENABLE: rd_byte = {enables[4:0], 3'b000};
            IPIRQ_IDX_FLAGS: rd_byte = {flags[4:0], 3'b000};
            IPIRQ_IDX_SELECT: rd_byte = byte_pin_select;
            IPIRQ_IDX_BYTE_CMP: rd_byte = byte_pin_compare;
            IPIRQ_IDX_NIB_CMP: rd_byte = {4'h0, nibble_pin_compare};
            IPIRQ_IDX_BYTE_DATA: rd_byte = byte_s2;
            IPIRQ_IDX_NIB_DATA: rd_byte = {4'h0, nib_s2};
            IPIRQ_IDX_IRQ_EN: rd_byte = {irq_en, 3'b000};
            IPIRQ_IDX_IRQ_CLR: rd_byte = 8'h00;
            default: mapped = 1'b0;
        endcase
    end

    // one-wait-state answer: ack or err the cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req_hit && mapped;
            wb_err_o <= req_hit && !mapped;
            wb_dat_o <= (req_hit && mapped && !wb_we_i) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            priority_reg <= IPIRQ_RST_PRIORITY;
            enables <= IPIRQ_RST_ENABLE;
            byte_pin_select <= IPIRQ_RST_SELECT;
            byte_pin_compare <= IPIRQ_RST_BYTE_CMP;
            nibble_pin_compare <= IPIRQ_RST_NIB_CMP;
            irq_en <= 5'h00;
        end else if (wr_stb) begin
            unique case (idx)
                IPIRQ_IDX_PRIORITY: priority_reg <= wbyte;
                IPIRQ_IDX_ENABLE: enables <= wbyte[7:IPIRQ_SYS_LSB];
                IPIRQ_IDX_SELECT: byte_pin_select <= wbyte;
                IPIRQ_IDX_BYTE_CMP: byte_pin_compare <= wbyte;
                IPIRQ_IDX_NIB_CMP: nibble_pin_compare <= wbyte[3:0];
                IPIRQ_IDX_IRQ_EN: irq_en <= wbyte[7:IPIRQ_SYS_LSB];
                default: ;
            endcase
        end
    end

    // pin synchronisers, two flops each
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            byte_s1 <= 8'h00;
            byte_s2 <= 8'h00;
            nib_s1 <= 4'h0;
            nib_s2 <= 4'h0;
            nib_prev <= 4'h0;
        end else begin
            byte_s1 <= byte_input_group_i;
            byte_s2 <= byte_s1;
            nib_s1 <= nibble_input_pin_i;
            nib_s2 <= nib_s1;
            nib_prev <= nib_s2;
        end
    end

    // byte group match: pins equal compare bits, unselected pins ignored
    assign match_now = (((byte_s2 ^ byte_pin_compare) & byte_pin_select) == 8'h00);
    // match history restarts at match after reset, so a mismatch standing after reset fires once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_prev <= 1'b1;
        end else begin
            match_prev <= match_now;
        end
    end

    // events: byte group on match->mismatch; nibble on compare-chosen edge
    always_comb begin
        event_set[0] = match_prev && !match_now;
        for (int i = 0; i < 4; i++) begin
            // compare 1: falling, 0: rising
            event_set[i+1] = nibble_pin_compare[i] ? (nib_prev[i] && !nib_s2[i])
                                                    : (!nib_prev[i] && nib_s2[i]);
        end
    end

    // flags: set wins over a clear in the same cycle
    assign clr_mask = (wr_stb && idx == IPIRQ_IDX_FLAGS) ? wbyte[7:IPIRQ_SYS_LSB] : 5'h00;
    assign irq_clr = (wr_stb && idx == IPIRQ_IDX_IRQ_CLR) ? wbyte[7:IPIRQ_SYS_LSB] : 5'h00;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= IPIRQ_RST_FLAGS;
        end else begin
            flags <= (flags & ~(clr_mask | irq_clr)) | event_set;
        end
    end

    // requests gated by enables; interrupt output from enabled flags
    assign sys_req_o = flags & enables;
    assign irq_o = |(flags & irq_en);

    // priorities and vectors
    assign byte_group_priority_o = priority_reg[IPIRQ_BYTE_PRIO_LSB +: 2];
    assign nibble_group_priority_o = priority_reg[IPIRQ_NIB_PRIO_LSB +: 2];
    assign vec_byte_o = IPIRQ_VEC_BYTE;
    assign vec_nib0_o = IPIRQ_VEC_NIB0;
    assign vec_nib1_o = IPIRQ_VEC_NIB0 + IPIRQ_VEC_STEP;
    assign vec_nib2_o = IPIRQ_VEC_NIB0 + 24'(2 * IPIRQ_VEC_STEP);
    assign vec_nib3_o = IPIRQ_VEC_NIB0 + 24'(3 * IPIRQ_VEC_STEP);

    // assertions
    sequence s_byte_fall;
        match_prev && !match_now;
    endsequence
    a_byte_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        s_byte_fall |=> flags[0]) else $error("byte flag not set");
    a_no_mis_to_mis: assert property (@(posedge clk_i) disable iff (rst_i)
        (!flags[0] && !match_prev) |=> !flags[0]) else $error("byte flag set on mismatch");
    a_nib_rise: assert property (@(posedge clk_i) disable iff (rst_i)
        (!nibble_pin_compare[0] && !nib_prev[0] && nib_s2[0]) |=> flags[1])
        else $error("nibble rise missed");
    a_nib_fall: assert property (@(posedge clk_i) disable iff (rst_i)
        (nibble_pin_compare[1] && nib_prev[1] && !nib_s2[1]) |=> flags[2])
        else $error("nibble fall missed");
    a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (clr_mask[0] && !event_set[0]) |=> !flags[0]) else $error("w1c failed");
    a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        (clr_mask[3] && event_set[3]) |=> flags[3]) else $error("event lost");
    a_req_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        !enables[2] |-> !sys_req_o[2]) else $error("disabled request");
    a_unselected: assert property (@(posedge clk_i) disable iff (rst_i)
        (byte_pin_select == 8'h00) |-> match_now)
        else $error("unselected pin matters");
    a_reset_vals: assert property (@(posedge clk_i)
        rst_i |=> (flags == 5'h00 && enables == 5'h00 && byte_pin_compare == 8'hFF))
        else $error("bad reset values");
    a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        (req_hit && mapped) |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");

    // independent helpers for the checks below
    logic [3:0] nib_edge; // compare-chosen edge per nibble pin
    logic [7:0] byte_miss; // selected byte pins off their compare level
    logic [4:0] any_clr; // every clear source of this cycle
    // an edge counts where the pin moved to the level opposite its compare bit
    assign nib_edge = (nib_prev ^ nib_s2) & (nib_s2 ^ nibble_pin_compare);
    assign byte_miss = (byte_s2 ^ byte_pin_compare) & byte_pin_select;
    assign any_clr = clr_mask | irq_clr;

    // byte group steps: a full match, then a break of it
    sequence s_byte_whole;
        byte_miss == 8'h00;
    endsequence
    sequence s_byte_broken;
        s_byte_whole ##1 byte_miss != 8'h00;
    endsequence
    // byte group steps: one mismatch following another
    sequence s_byte_still_off;
        byte_miss != 8'h00 ##1 byte_miss != 8'h00;
    endsequence
    // nibble steps: a pin level, then its opposite
    sequence s_nib0_fall;
        nib_s2[0] ##1 !nib_s2[0];
    endsequence
    sequence s_nib3_rise;
        !nib_s2[3] ##1 nib_s2[3];
    endsequence

    // a broken byte match raises the byte flag
    a_byte_break: assert property (@(posedge clk_i) disable iff (rst_i)
        s_byte_broken |=> flags[0])
        else $error("byte break missed");

    // mismatch after mismatch makes no event
    a_byte_repeat: assert property (@(posedge clk_i) disable iff (rst_i)
        s_byte_still_off |-> !event_set[0])
        else $error("byte event on repeat mismatch");

    // a standing full match makes no event
    a_byte_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (byte_miss == 8'h00) |-> !event_set[0])
        else $error("byte event while matching");

    // nibble pin 0 falling with compare 1 sets its flag
    a_nib0_fall_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_nib0_fall ##0 nibble_pin_compare[0]) |=> flags[1])
        else $error("nibble 0 fall missed");

    // nibble pin 3 rising with compare 0 sets its flag
    a_nib3_rise_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_nib3_rise ##0 !nibble_pin_compare[3]) |=> flags[4])
        else $error("nibble 3 rise missed");

    // every chosen nibble edge lands in its flag
    a_nib_edges: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((flags[4:1] & $past(nib_edge)) == $past(nib_edge)))
        else $error("nibble edge lost");

    // nibble flags rise only on a chosen edge
    a_nib_only_edges: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((flags[4:1] & ~$past(flags[4:1]) & ~$past(nib_edge)) == 4'h0))
        else $error("nibble flag without edge");

    // flags stay set until a clear names them
    a_flags_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (($past(flags) & ~$past(any_clr) & ~flags) == 5'h00))
        else $error("flag dropped without clear");

    // flags rise only from an event
    a_flags_from_event: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((flags & ~$past(flags) & ~$past(event_set)) == 5'h00))
        else $error("flag without event");

    // an event always wins over a clear
    a_set_wins_all: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((flags & $past(event_set)) == $past(event_set)))
        else $error("event lost to clear");

    // writing zeros clears nothing
    a_zero_no_effect: assert property (@(posedge clk_i) disable iff (rst_i)
        (any_clr == 5'h00)
        |=> (flags == ($past(flags) | $past(event_set))))
        else $error("flag changed without clear");

    // no request without its enable
    a_req_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        ((sys_req_o & ~enables) == 5'h00))
        else $error("request past disabled system");

    // byte group enable masks the whole group
    a_byte_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !enables[0] |-> !sys_req_o[0])
        else $error("byte request while disabled");

    // priority fields change only on their write
    a_prio_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_stb && idx == IPIRQ_IDX_PRIORITY)
        |=> ($stable(byte_group_priority_o) && $stable(nibble_group_priority_o)))
        else $error("priority moved");

    // enables change only on their write
    a_enable_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_stb && idx == IPIRQ_IDX_ENABLE) |=> $stable(enables))
        else $error("enables moved");

    // byte compare bits change only on their write
    a_cmp_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_stb && idx == IPIRQ_IDX_BYTE_CMP) |=> $stable(byte_pin_compare))
        else $error("byte compare moved");

    // nibble compare bits change only on their write
    a_nib_cmp_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_stb && idx == IPIRQ_IDX_NIB_CMP) |=> $stable(nibble_pin_compare))
        else $error("nibble compare moved");

    // select bits change only on their write
    a_sel_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_stb && idx == IPIRQ_IDX_SELECT) |=> $stable(byte_pin_select))
        else $error("select moved");

    // vectors climb in steps of two up to the byte group
    a_vec_order: assert property (@(posedge clk_i) disable iff (rst_i)
        (vec_nib3_o + IPIRQ_VEC_STEP == vec_byte_o)
        && (vec_nib2_o + IPIRQ_VEC_STEP == vec_nib3_o))
        else $error("vector order");

    // ack and err never together
    a_ack_err_excl: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wb_ack_o && wb_err_o))
        else $error("ack with err");

    // read data upper lanes are zero
    a_read_upper: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000))
        else $error("upper read lanes set");

    // a refused access leaves the control registers alone
    a_err_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (req_hit && !mapped) |=> ($stable(enables) && $stable(priority_reg)))
        else $error("refused access wrote");

    // reset clears priority and select
    a_reset_more: assert property (@(posedge clk_i)
        rst_i |=> (priority_reg == IPIRQ_RST_PRIORITY && byte_pin_select == IPIRQ_RST_SELECT))
        else $error("bad priority or select reset");

    // second sync flop follows the first by one edge
    a_sync_pipe: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((nib_s2 == $past(nib_s1)) && (byte_s2 == $past(byte_s1))))
        else $error("sync pipe broken");

    // interrupt only while some flag is set
    a_irq_needs_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o |-> (flags != 5'h00))
        else $error("irq without flag");
endmodule
`default_nettype wire
